// file: scfc_cfg.svh
`ifndef SCFC_CFG_SVH
`define SCFC_CFG_SVH
// Register byte addresses
`define SCFC_ADDR_RX_FIFO_CONFIG 4'h0
`define SCFC_ADDR_TX_FIFO_CONFIG 4'h1
`define SCFC_ADDR_RX_FIFO_STATUS 4'h2
`define SCFC_ADDR_DATA_BUFFER 4'h3
`define SCFC_ADDR_MODE 4'h4
`define SCFC_ADDR_IRQ_STATUS 4'h5
`define SCFC_ADDR_IRQ_MASK 4'h6
// Field positions
`define SCFC_BIT_CLEAR 7
`define SCFC_BIT_COND 6
`define SCFC_BIT_OVERRUN 7
`define SCFC_BIT_QEN 0
`define SCFC_BIT_RXIE 2
`define SCFC_BIT_TXIE 3
`define SCFC_BIT_DPX_LO 4
`define SCFC_BIT_DPX_HI 5
`define SCFC_IRQ_RX 0
`define SCFC_IRQ_TX 1
`define SCFC_IRQ_OVR 2
// Reset values, sizes and duplex codes
`define SCFC_CFG_RESET 8'h00
`define SCFC_DEPTH_HALF 3'h4
`define SCFC_DEPTH_FULL 3'h2
`define SCFC_DUPLEX_FULL 2'h3
`define SCFC_DUPLEX_TX 2'h2
`endif

// file: scfc_pkg.sv
package scfc_pkg;
  typedef struct packed {
    logic [7:0] rx_cfg_r;
    logic [7:0] tx_cfg_r;
    logic [7:0] mode_r;
    logic [2:0] irq_sts_r;
    logic [2:0] irq_msk_r;
    logic [2:0] rx_occupancy_r;
    logic [2:0] tx_occ_r;
    logic [1:0] rx_rd_ptr_r;
    logic [1:0] rx_wr_ptr_r;
    logic [1:0] tx_rd_ptr_r;
    logic [1:0] tx_wr_ptr_r;
    logic rx_overrun_flag_r;
    logic [31:0] readdata_r;
    logic resp_r;
    logic irq_r;
    logic rx_irq_req_r;
    logic tx_irq_req_r;
    logic tx_valid_r;
    logic [7:0] tx_byte_r;
    logic rx_ready_r;
  } scfc_state_s;
endpackage

// file: scfc_top.sv
`timescale 1ns/1ps
`include "scfc_cfg.svh"
module scfc_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Receive shift engine
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic rx_ready,
  // Transmit shift engine
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  // Interrupts
  output logic irq,
  output logic rx_irq_req,
  output logic tx_irq_req
);
  scfc_pkg::scfc_state_s s_r;
  scfc_pkg::scfc_state_s s_nxt;
  logic [7:0] rx_mem_r [4];
  logic [7:0] tx_mem_r [4];
  logic rx_push;
  logic rx_pop;
  logic tx_push;
  logic tx_pop;
  logic full_dpx;
  logic [2:0] rx_depth;
  logic [2:0] tx_depth;
  logic [2:0] rx_thr;
  logic [2:0] tx_thr;
  logic [2:0] rx_occ_new;
  logic [2:0] tx_occ_new;
  logic access;
  logic rd_buf;
  logic [2:0] evt;

  // Answer takes one cycle so read data can come from a flop
  assign access = (read | write) & ~s_r.resp_r;
  assign full_dpx = s_r.mode_r[`SCFC_BIT_DPX_HI:`SCFC_BIT_DPX_LO] == `SCFC_DUPLEX_FULL;

  always_comb
  begin
    rx_depth = full_dpx ? `SCFC_DEPTH_FULL : `SCFC_DEPTH_HALF;
    tx_depth = full_dpx ? `SCFC_DEPTH_FULL : `SCFC_DEPTH_HALF;
    if (full_dpx)
    begin
      rx_thr = s_r.rx_cfg_r[0] ? 3'h1 : 3'h2;
      tx_thr = s_r.tx_cfg_r[0] ? 3'h1 : 3'h0;
    end
    else
    begin
      rx_thr = (s_r.rx_cfg_r[1:0] == 2'h0) ? 3'h4 : {1'b0, s_r.rx_cfg_r[1:0]};
      tx_thr = {1'b0, s_r.tx_cfg_r[1:0]};
    end
  end

  // Half-duplex TX mode disables receive; transmit is not gated by any duplex mode
  assign rd_buf = access & read & (address == `SCFC_ADDR_DATA_BUFFER);
  assign rx_pop = rd_buf & (s_r.rx_occupancy_r != 3'h0);
  assign rx_push = rx_valid & s_r.rx_ready_r;
  assign tx_push = access & write & (address == `SCFC_ADDR_DATA_BUFFER)
    & (s_r.tx_occ_r < tx_depth);
  assign tx_pop = s_r.tx_valid_r & tx_ready;
  assign rx_occ_new = s_r.rx_occupancy_r + {2'h0, rx_push} - {2'h0, rx_pop};
  assign tx_occ_new = s_r.tx_occ_r + {2'h0, tx_push} - {2'h0, tx_pop};

  always_comb
  begin
    s_nxt = s_r;
    evt = 3'h0;
    s_nxt.resp_r = access;
    s_nxt.rx_occupancy_r = rx_occ_new;
    s_nxt.tx_occ_r = tx_occ_new;
    if (rx_push)
      s_nxt.rx_wr_ptr_r = s_r.rx_wr_ptr_r + 2'h1;
    if (rx_pop)
      s_nxt.rx_rd_ptr_r = s_r.rx_rd_ptr_r + 2'h1;
    if (tx_push)
      s_nxt.tx_wr_ptr_r = s_r.tx_wr_ptr_r + 2'h1;
    if (tx_pop)
      s_nxt.tx_rd_ptr_r = s_r.tx_rd_ptr_r + 2'h1;
    // Threshold events
    if (s_r.mode_r[`SCFC_BIT_QEN])
    begin
      if (rx_occ_new == rx_thr && rx_occ_new != s_r.rx_occupancy_r)
        evt[`SCFC_IRQ_RX] = 1'b1;
      if (s_r.rx_cfg_r[`SCFC_BIT_COND] && rx_pop && rx_occ_new >= rx_thr)
        evt[`SCFC_IRQ_RX] = 1'b1;
      if (tx_occ_new == tx_thr && tx_occ_new != s_r.tx_occ_r)
        evt[`SCFC_IRQ_TX] = 1'b1;
      if (s_r.tx_cfg_r[`SCFC_BIT_COND] && tx_pop && tx_occ_new > tx_thr)
        evt[`SCFC_IRQ_TX] = 1'b1;
    end
    evt[`SCFC_IRQ_RX] = evt[`SCFC_IRQ_RX] & s_r.mode_r[`SCFC_BIT_RXIE];
    evt[`SCFC_IRQ_TX] = evt[`SCFC_IRQ_TX] & s_r.mode_r[`SCFC_BIT_TXIE];
    if (rx_valid && !s_r.rx_ready_r)
    begin
      s_nxt.rx_overrun_flag_r = 1'b1;
      evt[`SCFC_IRQ_OVR] = 1'b1;
    end
    else if (rd_buf)
      s_nxt.rx_overrun_flag_r = 1'b0;
    s_nxt.rx_irq_req_r = evt[`SCFC_IRQ_RX];
    s_nxt.tx_irq_req_r = evt[`SCFC_IRQ_TX];
    // Register writes
    if (access && write)
    begin
      case (address)
        `SCFC_ADDR_RX_FIFO_CONFIG:
        begin
          s_nxt.rx_cfg_r = {1'b0, writedata[6], 4'h0, writedata[1:0]};
          if (writedata[`SCFC_BIT_CLEAR])
          begin
            s_nxt.rx_occupancy_r = 3'h0;
            s_nxt.rx_rd_ptr_r = 2'h0;
            s_nxt.rx_wr_ptr_r = 2'h0;
          end
        end
        `SCFC_ADDR_TX_FIFO_CONFIG:
        begin
          s_nxt.tx_cfg_r = {1'b0, writedata[6], 4'h0, writedata[1:0]};
          if (writedata[`SCFC_BIT_CLEAR])
          begin
            s_nxt.tx_occ_r = 3'h0;
            s_nxt.tx_wr_ptr_r = 2'h0;
            s_nxt.tx_rd_ptr_r = 2'h0;
          end
        end
        `SCFC_ADDR_MODE: s_nxt.mode_r = {2'h0, writedata[5:0]};
        `SCFC_ADDR_IRQ_STATUS: s_nxt.irq_sts_r = s_r.irq_sts_r & ~writedata[2:0];
        `SCFC_ADDR_IRQ_MASK: s_nxt.irq_msk_r = writedata[2:0];
        default: ;
      endcase
    end
    // Set wins over a simultaneous clear
    s_nxt.irq_sts_r = s_nxt.irq_sts_r | evt;
    s_nxt.irq_r = |(s_nxt.irq_sts_r & s_nxt.irq_msk_r);
    s_nxt.rx_ready_r = s_nxt.mode_r[`SCFC_BIT_QEN]
      & (s_nxt.mode_r[`SCFC_BIT_DPX_HI:`SCFC_BIT_DPX_LO] != `SCFC_DUPLEX_TX)
      & (s_nxt.rx_occupancy_r < rx_depth);
    s_nxt.tx_valid_r = s_nxt.tx_occ_r != 3'h0;
    s_nxt.tx_byte_r = tx_mem_r[s_nxt.tx_rd_ptr_r];
    // Head slot is written this cycle, memory lags a cycle, so bypass
    if (tx_push && s_nxt.tx_rd_ptr_r == s_r.tx_wr_ptr_r)
      s_nxt.tx_byte_r = writedata[7:0];
    // Read data
    s_nxt.readdata_r = 32'h0;
    if (access && read)
    begin
      case (address)
        `SCFC_ADDR_RX_FIFO_CONFIG: s_nxt.readdata_r = {24'h0, s_r.rx_cfg_r};
        `SCFC_ADDR_TX_FIFO_CONFIG: s_nxt.readdata_r = {24'h0, s_r.tx_cfg_r};
        `SCFC_ADDR_RX_FIFO_STATUS:
          s_nxt.readdata_r = {24'h0, s_r.rx_overrun_flag_r, 4'h0, s_r.rx_occupancy_r};
        `SCFC_ADDR_DATA_BUFFER: s_nxt.readdata_r = {24'h0, rx_mem_r[s_r.rx_rd_ptr_r]};
        `SCFC_ADDR_MODE: s_nxt.readdata_r = {24'h0, s_r.mode_r};
        `SCFC_ADDR_IRQ_STATUS: s_nxt.readdata_r = {29'h0, s_r.irq_sts_r};
        `SCFC_ADDR_IRQ_MASK: s_nxt.readdata_r = {29'h0, s_r.irq_msk_r};
        default: s_nxt.readdata_r = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // Storage has no reset; a data buffer read returns the head slot even when the RX level is zero
  always_ff @(posedge clk)
  begin
    if (rx_push)
      rx_mem_r[s_r.rx_wr_ptr_r] <= rx_byte;
    if (tx_push)
      tx_mem_r[s_r.tx_wr_ptr_r] <= writedata[7:0];
  end

  assign readdata = s_r.readdata_r;
  assign waitrequest = ~s_r.resp_r;
  assign rx_ready = s_r.rx_ready_r;
  assign tx_valid = s_r.tx_valid_r;
  assign tx_byte = s_r.tx_byte_r;
  assign irq = s_r.irq_r;
  assign rx_irq_req = s_r.rx_irq_req_r;
  assign tx_irq_req = s_r.tx_irq_req_r;
endmodule

// file: scfc_engine.sv
`timescale 1ns/1ps
module scfc_engine (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bench commands
  input wire logic send,
  input wire logic [7:0] send_byte,
  input wire logic stall,
  // Queue side
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic tx_ready
);
  // A byte is offered one cycle, ready or not, as a real shifter would
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      rx_valid <= 1'b0;
      rx_byte <= 8'h00;
      tx_ready <= 1'b0;
    end
    else
    begin
      rx_valid <= send;
      rx_byte <= send ? send_byte : ~rx_byte;
      tx_ready <= !stall;
    end
endmodule

// file: scfc_props.sv
`timescale 1ns/1ps
module scfc_props (
  // Bus ports of the top except writedata, plus tx_valid, tx_ready and the two request pulses
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_irq_req,
  input wire logic tx_irq_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_ans; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_once; !waitrequest |=> waitrequest; endproperty
  a_once: assert property (p_once) else $error("long answer");
  property p_rxp; rx_irq_req |=> !rx_irq_req; endproperty
  a_rxp: assert property (p_rxp) else $error("rx pulse long");
  property p_txp; tx_irq_req |=> !tx_irq_req; endproperty
  a_txp: assert property (p_txp) else $error("tx pulse long");
  property p_rd0; waitrequest |-> readdata == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("stray readdata");
  property p_rclr; read && !waitrequest && address == 4'h0 |-> !readdata[7]; endproperty
  a_rclr: assert property (p_rclr) else $error("rx clear reads one");
  property p_tclr; read && !waitrequest && address == 4'h1 |-> !readdata[7]; endproperty
  a_tclr: assert property (p_tclr) else $error("tx clear reads one");
  property p_hold; tx_valid && !tx_ready && !write |=> tx_valid; endproperty
  a_hold: assert property (p_hold) else $error("tx byte lost");
endmodule
bind scfc_top scfc_props chk_i (.clk(clk), .rst_b(rst_b), .address(address), .read(read),
  .write(write), .readdata(readdata), .waitrequest(waitrequest), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req));

// file: tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic send = 1'b0;
  logic stall = 1'b1;
  logic [7:0] send_byte = 8'h00;
  logic [7:0] tx_exp = 8'hB0;
  logic [31:0] readdata, q;
  logic [7:0] rx_byte, tx_byte;
  logic waitrequest, rx_valid, rx_ready, tx_valid, tx_ready, irq, rx_irq_req, tx_irq_req;
  int n_fail = 0, n_checks = 0, n_rxi = 0, n_txi = 0, cyc = 0;
  always #50 clk = ~clk;
  scfc_top DUT (.clk, .rst_b, .address, .read, .write, .writedata, .readdata, .waitrequest,
    .rx_valid, .rx_byte, .rx_ready, .tx_valid, .tx_byte, .tx_ready, .irq, .rx_irq_req,
    .tx_irq_req);
  scfc_engine eng (.clk, .rst_b, .send, .send_byte, .stall, .rx_valid, .rx_byte, .tx_ready);
  task finish_test;
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    n_rxi <= n_rxi + (rx_irq_req === 1'b1);
    n_txi <= n_txi + (tx_irq_req === 1'b1);
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      chk("tx order", {24'h0, tx_exp}, {24'h0, tx_byte});
      tx_exp <= tx_exp + 8'h01;
    end
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test;
    end
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  // Pre-edge values are seen, so the answer is taken at its own edge
  task bus(input logic [3:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    address <= a; read <= !w; write <= w; writedata <= {24'h0, d};
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0; write <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 8'h00);
    chk($sformatf("reg %h", a), exp, q);
  endtask
  task push(input int n);
    repeat (n)
    begin
      @(posedge clk);
      send <= 1'b1; send_byte <= 8'hA0 + 8'(n_checks);
      @(posedge clk);
      send <= 1'b0;
    end
    repeat (3) @(posedge clk);
  endtask
  task t_reset;
    rd(4'h0, 0);
    rd(4'h1, 0);
    rd(4'h2, 0);
    rd(4'hF, 0);
  endtask
  task t_rx;
    bus(4'h4, 1'b1, 8'h05);
    bus(4'h6, 1'b1, 8'h01);
    bus(4'h0, 1'b1, 8'h42);
    push(2);
    chk("rx irq", 1, n_rxi);
    rd(4'h2, 32'h02);
    push(3);
    rd(4'h2, 32'h84);
    chk("irq", 1, irq);
    rd(4'h3, 32'hA4);
    rd(4'h2, 32'h03);
    chk("rx irq", 2, n_rxi);
    bus(4'h6, 1'b1, 8'h00);
    chk("irq", 0, irq);
    bus(4'h6, 1'b1, 8'h01);
    bus(4'h5, 1'b1, 8'h07);
    chk("irq", 0, irq);
    bus(4'h0, 1'b1, 8'hC2);
    rd(4'h2, 0);
    rd(4'h0, 32'h42);
  endtask
  task t_dpx;
    bus(4'h4, 1'b1, 8'h35);
    bus(4'h0, 1'b1, 8'h03);
    push(1);
    chk("rx irq", 3, n_rxi);
    push(2);
    rd(4'h2, 32'h82);
    chk("rx ready", 0, rx_ready);
  endtask
  task t_tx;
    bus(4'h4, 1'b1, 8'h29);
    bus(4'h1, 1'b1, 8'h01);
    for (int i = 0; i < 4; i++) bus(4'h3, 1'b1, 8'hB0 + 8'(i));
    chk("tx byte", 8'hB0, tx_byte);
    stall <= 1'b0;
    repeat (12) @(posedge clk);
    chk("tx irq", 2, n_txi);
    stall <= 1'b1;
    bus(4'h3, 1'b1, 8'hC0);
    bus(4'h1, 1'b1, 8'h81);
    chk("tx valid", 0, tx_valid);
    rd(4'h1, 32'h01);
  endtask
  // Full duplex TX: code 10 means empty, third byte refused, one pop at a time
  task t_tx_dpx;
    bus(4'h4, 1'b1, 8'h39);
    bus(4'h1, 1'b1, 8'hC2);
    for (int i = 4; i < 7; i++) bus(4'h3, 1'b1, 8'hB0 + 8'(i));
    chk("tx irq", 3, n_txi);
    repeat (2)
    begin
      @(posedge clk);
      stall <= 1'b0;
      @(posedge clk);
      stall <= 1'b1;
      repeat (3) @(posedge clk);
    end
    chk("tx irq", 5, n_txi);
    chk("tx valid", 0, tx_valid);
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_rx;
    t_dpx;
    t_tx;
    t_tx_dpx;
    finish_test;
  end
endmodule
